// >>> pfwc_bank.sv
// Proxy filter enable register bank with wake packet capture buffer, Wishbone classic slave
//
// Overview of operation
// - First 128 bytes of the wake packet are captured for software read-back.
// - Buffer words sit at 0x5A00 plus four times index, indices 0 to 31.
// - Buffer contents survive every reset and start undefined.
// - Each filter enable bit turns its filter on at one, off at zero.
// - Bit 0 zero: offload only in D3; one: offload always.
// - Offload acts only while host and management gate bits are both one.
// - Bit 2 enables proxying of exact unicast address matches.
// - Bit 3 enables directed multicast, bit 4 enables broadcast proxying.
// - Bit 5 enables ARP requests whose target matches an IPv4 address filter.
// - Bit 6 enables directed IPv4, bit 7 directed IPv6 proxying.
// - Bit 9 enables proxying of any IPv6 neighbor solicitation.
// - Bit 10 enables neighbor solicitations whose target matches an IPv6 filter.
// - Bit 11 enables any ARP request passing main receive filtering.
// - Bits 16 to 23 enable flexible filters 0 to 7 in order.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps

module pfwc_bank (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [15:0]            wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire pfwc_pkg::pfwc_rx_byte_t rx_i,
    input  wire pfwc_pkg::pfwc_match_t  match_i,
    input  wire logic                   low_power_i,
    output logic                        proxy_candidate_o,
    output logic                        offload_active_o,
    output logic                        capture_held_o
);

    // ==========================================================
    // Decode helpers
    // Capture buffer window: 32 aligned words
    function automatic logic buf_hit(input logic [15:0] adr);
        buf_hit = (adr[15:2] >= pfwc_pkg::PFWC_CAPTURE_BASE[15:2]) &&
                  (adr[15:2] <= pfwc_pkg::PFWC_CAPTURE_LAST[15:2]);
    endfunction

    // Byte-lane merge for writable registers
    function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
        merge_sel = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge_sel[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

    // One filter's contribution: its match flag passes only while its enable bit is one
    function automatic logic en_hit(input logic [31:0] hits, input logic [31:0] en, input int unsigned idx);
        en_hit = hits[idx] && en[idx];
    endfunction

    // ==========================================================
    // Bus request qualification
    logic        req;
    logic        wr_req;
    logic        rd_req;
    logic [31:0] filter_en_q;
    logic [1:0]  gate_q;
    logic [7:0]  cnt_q;
    logic        allowed;
    logic [31:0] rd_word;
    logic [31:0] buf_word;
    logic        rearm;
    pfwc_pkg::pfwc_cap_state_t state_q;

    // A request is served once; the cycle after ack is ignored so the master can drop stb
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req = req && wb_we_i;
    assign rd_req = req && !wb_we_i;
    assign rearm  = wr_req && (wb_adr_i[15:2] == pfwc_pkg::PFWC_CONTROL[15:2]) && wb_sel_i[0] &&
                    wb_dat_i[pfwc_pkg::PFWC_CTL_REARM];

    // ==========================================================
    // Capture memory
    // No reset on purpose: contents must outlive every reset
    logic [7:0] cap_mem [0:pfwc_pkg::PFWC_CAP_BYTES-1];
    logic       mem_we;

    assign mem_we = rx_i.valid && (cnt_q < pfwc_pkg::PFWC_CAP_LIMIT || rx_i.sof) &&
                    (state_q == pfwc_pkg::PFWC_CAP_FILL || (state_q == pfwc_pkg::PFWC_CAP_IDLE && rx_i.sof));

    // Byte write; a start byte always lands at offset zero
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            cap_mem[rx_i.sof ? 7'h00 : cnt_q[6:0]] <= rx_i.data;
        end
    end

    // First byte of the packet sits in the low lane of word zero
    assign buf_word = {cap_mem[{wb_adr_i[6:2], 2'h3}], cap_mem[{wb_adr_i[6:2], 2'h2}],
                       cap_mem[{wb_adr_i[6:2], 2'h1}], cap_mem[{wb_adr_i[6:2], 2'h0}]};

    // ==========================================================
    // Capture state machine
    // A wake that ends in the same cycle as a rearm wins, so the packet is not lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= pfwc_pkg::PFWC_CAP_IDLE;
        end else begin
            case (state_q)
                pfwc_pkg::PFWC_CAP_IDLE: begin
                    if (rx_i.valid && rx_i.sof) begin
                        state_q <= (rx_i.eof && rx_i.wake) ? pfwc_pkg::PFWC_CAP_HELD
                                 : (rx_i.eof ? pfwc_pkg::PFWC_CAP_IDLE : pfwc_pkg::PFWC_CAP_FILL);
                    end
                end
                pfwc_pkg::PFWC_CAP_FILL: begin
                    if (rx_i.valid && rx_i.eof) begin
                        state_q <= rx_i.wake ? pfwc_pkg::PFWC_CAP_HELD : pfwc_pkg::PFWC_CAP_IDLE;
                    end
                end
                pfwc_pkg::PFWC_CAP_HELD: begin
                    if (rearm) begin
                        state_q <= pfwc_pkg::PFWC_CAP_IDLE;
                    end
                end
                default: begin
                    state_q <= pfwc_pkg::PFWC_CAP_IDLE;
                end
            endcase
        end
    end

    // Byte count, saturating at the buffer size; held frozen with the buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else if (mem_we) begin
            cnt_q <= rx_i.sof ? 8'h01 : cnt_q + 8'h01;
        end
    end

    // ==========================================================
    // Filter enable and gate registers
    // Reserved positions are masked off so they always read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filter_en_q <= pfwc_pkg::PFWC_FILTER_EN_RST;
        end else if (wr_req && wb_adr_i[15:2] == pfwc_pkg::PFWC_FILTER_EN[15:2]) begin
            filter_en_q <= merge_sel(filter_en_q, wb_dat_i, wb_sel_i) & pfwc_pkg::PFWC_FILTER_EN_MASK;
        end
    end

    // Host and management offload gates
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_q <= pfwc_pkg::PFWC_GATE_RST;
        end else if (wr_req && wb_adr_i[15:2] == pfwc_pkg::PFWC_CONTROL[15:2] && wb_sel_i[0]) begin
            gate_q <= wb_dat_i[1:0];
        end
    end

    // ==========================================================
    // Per-filter gating
    // Built from the field positions, not a mask, so a reserved or mode bit never acts as a filter
    logic [31:0] gated_hits;
    logic [7:0]  flex_hits;

    // Flexible filters 0 to 7 sit on consecutive enable bits in ascending order
    for (genvar f = 0; f < pfwc_pkg::PFWC_FLEX_COUNT; f++) begin : g_flex
        assign flex_hits[f] = en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_FLEX_LSB + f);
    end

    // Predefined filters, each passing only its own match flag
    always_comb begin
        gated_hits = 32'h0000_0000;
        gated_hits[pfwc_pkg::PFWC_UNICAST_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_UNICAST_BIT);
        gated_hits[pfwc_pkg::PFWC_GROUP_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_GROUP_BIT);
        gated_hits[pfwc_pkg::PFWC_ALL_STA_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_ALL_STA_BIT);
        gated_hits[pfwc_pkg::PFWC_ARP_TGT_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_ARP_TGT_BIT);
        gated_hits[pfwc_pkg::PFWC_IPV4_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_IPV4_BIT);
        gated_hits[pfwc_pkg::PFWC_IPV6_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_IPV6_BIT);
        gated_hits[pfwc_pkg::PFWC_NS_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_NS_BIT);
        gated_hits[pfwc_pkg::PFWC_NS_TGT_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_NS_TGT_BIT);
        gated_hits[pfwc_pkg::PFWC_ARP_BIT] =
            en_hit(match_i.hits, filter_en_q, pfwc_pkg::PFWC_ARP_BIT);
        gated_hits[pfwc_pkg::PFWC_FLEX_LSB +: pfwc_pkg::PFWC_FLEX_COUNT] = flex_hits;
    end

    // ==========================================================
    // Offload decision
    // Both gates needed; full-power mode lifts the low-power-only restriction
    assign allowed = gate_q[pfwc_pkg::PFWC_CTL_HOST_GATE] && gate_q[pfwc_pkg::PFWC_CTL_MGMT_GATE] &&
                     (filter_en_q[pfwc_pkg::PFWC_FULL_POWER_BIT] || low_power_i);

    // Registered outputs; a match of a disabled filter never counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            proxy_candidate_o <= 1'b0;
            offload_active_o  <= 1'b0;
            capture_held_o    <= 1'b0;
        end else begin
            proxy_candidate_o <= allowed && |gated_hits;
            offload_active_o  <= allowed;
            capture_held_o    <= (state_q == pfwc_pkg::PFWC_CAP_HELD);
        end
    end

    // ==========================================================
    // Read mux; unmapped addresses read zero and still get an ack
    always_comb begin
        rd_word = 32'h0000_0000;
        if (buf_hit(wb_adr_i)) begin
            rd_word = buf_word;
        end else if (wb_adr_i[15:2] == pfwc_pkg::PFWC_FILTER_EN[15:2]) begin
            rd_word = filter_en_q;
        end else if (wb_adr_i[15:2] == pfwc_pkg::PFWC_STATUS[15:2]) begin
            rd_word[pfwc_pkg::PFWC_STS_HELD]                         = (state_q == pfwc_pkg::PFWC_CAP_HELD);
            rd_word[pfwc_pkg::PFWC_STS_ALLOWED]                      = allowed;
            rd_word[pfwc_pkg::PFWC_STS_CNT_LSB +: 8]                 = cnt_q;
        end else if (wb_adr_i[15:2] == pfwc_pkg::PFWC_CONTROL[15:2]) begin
            rd_word[1:0] = gate_q;
        end
    end

    // Single-cycle answer: ack and data one edge after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd_req) begin
                wb_dat_o <= rd_word;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wake_end;
        state_q == pfwc_pkg::PFWC_CAP_FILL && rx_i.valid && rx_i.eof && rx_i.wake;
    endsequence

    sequence s_held_then_hold;
        state_q == pfwc_pkg::PFWC_CAP_HELD ##1 state_q == pfwc_pkg::PFWC_CAP_HELD;
    endsequence

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

    property p_wake_holds;
        s_wake_end |=> state_q == pfwc_pkg::PFWC_CAP_HELD ##1 capture_held_o;
    endproperty
    a_wake_holds: assert property (p_wake_holds) else $error("wake packet end did not freeze buffer");

    property p_held_frozen;
        state_q == pfwc_pkg::PFWC_CAP_HELD |-> !mem_we && cnt_q <= pfwc_pkg::PFWC_CAP_LIMIT;
    endproperty
    a_held_frozen: assert property (p_held_frozen) else $error("buffer written while held");

    property p_held_no_rearm;
        s_held_then_hold |-> !$past(rearm);
    endproperty
    a_held_no_rearm: assert property (p_held_no_rearm) else $error("held state survived a rearm");

    property p_buf_read;
        rd_req && buf_hit(wb_adr_i) |=> wb_ack_o && wb_dat_o == $past(buf_word);
    endproperty
    a_buf_read: assert property (p_buf_read) else $error("buffer word not returned");

    property p_enable_write;
        wr_req && wb_adr_i[15:2] == pfwc_pkg::PFWC_FILTER_EN[15:2] && wb_sel_i == 4'hf
            |=> filter_en_q == ($past(wb_dat_i) & pfwc_pkg::PFWC_FILTER_EN_MASK);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("filter enable write not stored");

    property p_enabled_only;
        proxy_candidate_o |-> $past(|(match_i.hits & filter_en_q & pfwc_pkg::PFWC_FILTER_HIT_MASK));
    endproperty
    a_enabled_only: assert property (p_enabled_only) else $error("candidate from disabled filter");

    property p_gates;
        offload_active_o |-> $past(gate_q) == 2'h3;
    endproperty
    a_gates: assert property (p_gates) else $error("offload active without both gates");

    property p_mode;
        offload_active_o && !$past(filter_en_q[pfwc_pkg::PFWC_FULL_POWER_BIT]) |-> $past(low_power_i);
    endproperty
    a_mode: assert property (p_mode) else $error("offload outside low power in low-power-only mode");

    property p_candidate_fires;
        allowed && |(match_i.hits & filter_en_q & pfwc_pkg::PFWC_FILTER_HIT_MASK) |=> proxy_candidate_o;
    endproperty
    a_candidate_fires: assert property (p_candidate_fires) else $error("enabled match not flagged");

    property p_full_power;
        gate_q == 2'h3 && filter_en_q[pfwc_pkg::PFWC_FULL_POWER_BIT] |=> offload_active_o;
    endproperty
    a_full_power: assert property (p_full_power) else $error("full-power mode did not allow offload");

    property p_rearm;
        state_q == pfwc_pkg::PFWC_CAP_HELD && rearm |=> state_q == pfwc_pkg::PFWC_CAP_IDLE ##1 !capture_held_o;
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearm did not release the buffer");

endmodule

// >>> pfwc_pkg.sv
// Package: offsets, field positions, reset values and carrier types of the proxy filter / wake capture bank
package pfwc_pkg;

    // ==========================================================
    // Register map (byte addresses on a 16-bit Wishbone address)
    localparam logic [15:0] PFWC_CAPTURE_BASE = 16'h5a00;
    localparam logic [15:0] PFWC_CAPTURE_LAST = 16'h5a7c;
    localparam logic [15:0] PFWC_FILTER_EN    = 16'h5f60;
    localparam logic [15:0] PFWC_STATUS       = 16'h5f68;
    localparam logic [15:0] PFWC_CONTROL      = 16'h5f6c;

    // ==========================================================
    // Capture buffer geometry
    localparam int unsigned PFWC_CAP_BYTES = 128;
    localparam logic [7:0]  PFWC_CAP_LIMIT = 8'h80;

    // ==========================================================
    // Filter enable fields
    localparam int unsigned PFWC_FULL_POWER_BIT = 0;
    localparam int unsigned PFWC_UNICAST_BIT    = 2;
    localparam int unsigned PFWC_GROUP_BIT      = 3;
    localparam int unsigned PFWC_ALL_STA_BIT    = 4;
    localparam int unsigned PFWC_ARP_TGT_BIT    = 5;
    localparam int unsigned PFWC_IPV4_BIT       = 6;
    localparam int unsigned PFWC_IPV6_BIT       = 7;
    localparam int unsigned PFWC_NS_BIT         = 9;
    localparam int unsigned PFWC_NS_TGT_BIT     = 10;
    localparam int unsigned PFWC_ARP_BIT        = 11;
    localparam int unsigned PFWC_FLEX_LSB       = 16;
    localparam int unsigned PFWC_FLEX_COUNT     = 8;
    // Writable positions; reserved bits 1, 8, 15:12, 31:24 store nothing and read zero
    localparam logic [31:0] PFWC_FILTER_EN_MASK  = 32'h00ff_0efd;
    // Match bits that count as filters (offload mode bit excluded)
    localparam logic [31:0] PFWC_FILTER_HIT_MASK = 32'h00ff_0efc;
    localparam logic [31:0] PFWC_FILTER_EN_RST   = 32'h0000_0000;

    // ==========================================================
    // Own control / status fields
    localparam int unsigned PFWC_CTL_HOST_GATE = 0;
    localparam int unsigned PFWC_CTL_MGMT_GATE = 1;
    localparam int unsigned PFWC_CTL_REARM     = 2;
    localparam logic [1:0]  PFWC_GATE_RST      = 2'h0;
    localparam int unsigned PFWC_STS_HELD      = 0;
    localparam int unsigned PFWC_STS_ALLOWED   = 1;
    localparam int unsigned PFWC_STS_CNT_LSB   = 8;

    // ==========================================================
    // Capture state machine, one-hot
    typedef enum logic [2:0] {
        PFWC_CAP_IDLE = 3'b001,
        PFWC_CAP_FILL = 3'b010,
        PFWC_CAP_HELD = 3'b100
    } pfwc_cap_state_t;

    // Received byte stream from the receive path
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic       wake;
        logic [7:0] data;
    } pfwc_rx_byte_t;

    // Filter match flags, laid out like the enable register
    typedef struct packed {
        logic [31:0] hits;
    } pfwc_match_t;

endpackage

// >>> tb_pfwc_bank.sv
// Self-checking testbench for the proxy filter enable and wake capture register bank
`timescale 1ns/1ps

module tb_pfwc_bank;
    // ==========================================================
    // Stimulus signals and counters
    logic                     clk_i    = 1'b0;
    logic                     rst_i    = 1'b1;
    logic                     cyc      = 1'b0;
    logic                     stb      = 1'b0;
    logic                     we       = 1'b0;
    logic [15:0]              adr      = 16'h0000;
    logic [3:0]               sel      = 4'h0;
    logic [31:0]              dat      = 32'h0000_0000;
    logic                     low_pwr  = 1'b0;
    pfwc_pkg::pfwc_rx_byte_t  rx       = '0;
    pfwc_pkg::pfwc_match_t    mt       = '0;
    logic [31:0]              wb_dat_o;
    logic                     wb_ack_o;
    logic                     cand_o;
    logic                     offl_o;
    logic                     held_o;
    int                       err_total    = 0;
    int                       total_checks = 0;
    int                       cycles       = 0;

    pfwc_bank dut (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .wb_cyc_i          (cyc),
        .wb_stb_i          (stb),
        .wb_we_i           (we),
        .wb_adr_i          (adr),
        .wb_sel_i          (sel),
        .wb_dat_i          (dat),
        .wb_dat_o          (wb_dat_o),
        .wb_ack_o          (wb_ack_o),
        .rx_i              (rx),
        .match_i           (mt),
        .low_power_i       (low_pwr),
        .proxy_candidate_o (cand_o),
        .offload_active_o  (offl_o),
        .capture_held_o    (held_o)
    );

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    // ==========================================================
    // Shared tasks
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    // Classic single cycle; request held until ack is sampled high at an edge
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        // Wait for ack however long it takes; only the bench-wide cycle limit ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk32(q & mask, exp);
    endtask

    function automatic logic [7:0] bv(input int k, input logic [7:0] s);
        return s + 8'(k * 7);
    endfunction

    function automatic logic [31:0] wexp(input int w, input logic [7:0] s);
        return {bv(4*w+3, s), bv(4*w+2, s), bv(4*w+1, s), bv(4*w, s)};
    endfunction

    // One packet, one byte per cycle, then a few idle cycles for the held flag to settle
    task automatic send_pkt(input int n, input logic wk, input logic [7:0] s);
        for (int k = 0; k < n; k++) begin
            @(posedge clk_i);
            rx <= {1'b1, k == 0, k == n-1, wk && (k == n-1), bv(k, s)};
        end
        @(posedge clk_i);
        rx <= '0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_and_fields();
        logic [31:0] q;
        rd_chk(pfwc_pkg::PFWC_FILTER_EN, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(pfwc_pkg::PFWC_CONTROL, 32'h0000_0003, 32'h0000_0000);
        wr(pfwc_pkg::PFWC_FILTER_EN, 32'hffff_ffff);
        rd_chk(pfwc_pkg::PFWC_FILTER_EN, 32'hffff_ffff, 32'h00ff_0efd);
        wb(1'b1, pfwc_pkg::PFWC_FILTER_EN, 32'h0000_0000, 4'h1, q);
        rd_chk(pfwc_pkg::PFWC_FILTER_EN, 32'hffff_ffff, 32'h00ff_0e00);
        wb(1'b1, pfwc_pkg::PFWC_FILTER_EN, 32'h0000_0000, 4'hc, q);
        rd_chk(pfwc_pkg::PFWC_FILTER_EN, 32'hffff_ffff, 32'h0000_0e00);
        wr(16'h5f70, 32'h1234_5678);
        rd_chk(16'h5f70, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(16'h5a80, 32'hffff_ffff, 32'h0000_0000);
        $display("test reset_and_fields done");
    endtask

    task automatic t_offload_gate();
        // gates, full-power bit, low-power input, expected offload
        logic [4:0] tbl [5] = '{5'h18, 5'h1b, 5'h1d, 5'h0e, 5'h16};
        for (int i = 0; i < 5; i++) begin
            wr(pfwc_pkg::PFWC_CONTROL, {30'h0, tbl[i][4:3]});
            wr(pfwc_pkg::PFWC_FILTER_EN, {31'h0, tbl[i][2]});
            @(posedge clk_i);
            low_pwr <= tbl[i][1];
            repeat (2) @(posedge clk_i);
            #1;
            chk1(offl_o, tbl[i][0]);
            rd_chk(pfwc_pkg::PFWC_STATUS, 32'h0000_0002, {30'h0, tbl[i][0], 1'b0});
        end
        $display("test offload_gate done");
    endtask

    task automatic t_candidates();
        logic [31:0] hm;
        hm = pfwc_pkg::PFWC_FILTER_HIT_MASK;
        wr(pfwc_pkg::PFWC_CONTROL, 32'h0000_0003);
        for (int b = 1; b < 24; b++) begin
            if (hm[b]) begin
                @(posedge clk_i);
                mt.hits <= 32'h0000_0001 << b;
                wr(pfwc_pkg::PFWC_FILTER_EN, 32'h0000_0001 | (32'h0000_0001 << b));
                repeat (2) @(posedge clk_i);
                #1;
                chk1(cand_o, 1'b1);
                wr(pfwc_pkg::PFWC_FILTER_EN, 32'h00ff_0efd & ~(32'h0000_0001 << b));
                repeat (2) @(posedge clk_i);
                #1;
                chk1(cand_o, 1'b0);
            end
        end
        wr(pfwc_pkg::PFWC_FILTER_EN, 32'h00ff_0efd);
        @(posedge clk_i);
        mt.hits <= 32'h00ff_0efc;
        wr(pfwc_pkg::PFWC_CONTROL, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        #1;
        chk1(cand_o, 1'b0);
        @(posedge clk_i);
        mt.hits <= 32'h0000_0000;
        $display("test candidates done");
    endtask

    task automatic t_capture();
        send_pkt(130, 1'b1, 8'h11);
        chk1(held_o, 1'b1);
        rd_chk(pfwc_pkg::PFWC_STATUS, 32'h0000_ff03, 32'h0000_8001);
        for (int w = 0; w < 32; w++) begin
            rd_chk(pfwc_pkg::PFWC_CAPTURE_BASE + 16'(4*w), 32'hffff_ffff, wexp(w, 8'h11));
        end
        send_pkt(4, 1'b1, 8'h77);
        wr(pfwc_pkg::PFWC_CAPTURE_BASE, 32'hdead_beef);
        rd_chk(pfwc_pkg::PFWC_CAPTURE_BASE, 32'hffff_ffff, wexp(0, 8'h11));
        // Mid-run reset: buffer contents must survive it
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk1(held_o, 1'b0);
        rd_chk(pfwc_pkg::PFWC_FILTER_EN, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(pfwc_pkg::PFWC_CAPTURE_LAST, 32'hffff_ffff, wexp(31, 8'h11));
        send_pkt(4, 1'b0, 8'h40);
        chk1(held_o, 1'b0);
        rd_chk(pfwc_pkg::PFWC_CAPTURE_BASE, 32'hffff_ffff, wexp(0, 8'h40));
        send_pkt(1, 1'b1, 8'h90);
        chk1(held_o, 1'b1);
        rd_chk(pfwc_pkg::PFWC_STATUS, 32'h0000_ff03, 32'h0000_0101);
        rd_chk(pfwc_pkg::PFWC_CAPTURE_BASE, 32'h0000_00ff, 32'h0000_0090);
        wr(pfwc_pkg::PFWC_CONTROL, 32'h0000_0004);
        repeat (3) @(posedge clk_i);
        #1;
        chk1(held_o, 1'b0);
        $display("test capture done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_and_fields();
        t_offload_gate();
        t_candidates();
        t_capture();
        end_of_test();
    end
endmodule
